// file: hdl/pit_pkg.sv
/*
 * constants for the three-channel programmable interval timer:
 * register indices, control word fields, mode and access codes.
 * assumes a classic wishbone slave with 32-bit data, byte data in bits 7:0.
 */
// Functional notes
// - mode field picks one of six modes
// - format bit selects binary or four BCD digits
// - control write clears counter, zero unreadable
// - zero count means 65536 clocks
// - square count one gives 65537 clocks
// - terminal-count mode output low, high at end
// - low gate suspends terminal-count mode counting
// - rewrite stops count, restarts after full load
// - one-shot output high, gate edge starts low
// - one-shot ignores gate low, edge retriggers
// - rate mode starts after load or gate edge
// - rate mode one-clock low pulse every n
// - rate rewrite applies after current pulse
// - low gate forces high, edge restarts count
// - square wave period n, odd split unevenly
// - counts go down, square mode by two
// - square rewrite applies at next output change
// - software strobe single low pulse at end
// - hardware strobe gate-triggered, strobe output
// - latch command snapshots count without disturbing
// - access field selects latch, low, high, both
// - select code three is an illegal combination
// - address three is write-only control word
package pit_pkg;
    // register indices, byte address is four times the index
    localparam logic [1:0] PIT_IDX_CNT0 = 2'h0;
    localparam logic [1:0] PIT_IDX_CNT1 = 2'h1;
    localparam logic [1:0] PIT_IDX_CNT2 = 2'h2;
    localparam logic [1:0] PIT_IDX_CTRL = 2'h3;
    localparam int         PIT_IDX_LSB  = 2;
    // control word fields
    localparam int PIT_CW_SEL_LSB = 6;
    localparam int PIT_CW_ACC_LSB = 4;
    localparam int PIT_CW_MODE_LSB = 1;
    localparam int PIT_CW_BCD_BIT = 0;
    localparam logic [1:0] PIT_SEL_ILLEGAL = 2'h3;
    // byte access codes
    localparam logic [1:0] PIT_ACC_LATCH = 2'h0;
    localparam logic [1:0] PIT_ACC_LSB   = 2'h1;
    localparam logic [1:0] PIT_ACC_MSB   = 2'h2;
    localparam logic [1:0] PIT_ACC_BOTH  = 2'h3;
    // mode codes, rate and square ignore the top bit
    localparam logic [2:0] PIT_MODE_TC    = 3'h0;
    localparam logic [2:0] PIT_MODE_ONESH = 3'h1;
    localparam logic [1:0] PIT_MODE_RATE  = 2'h2;
    localparam logic [1:0] PIT_MODE_SQR   = 2'h3;
    localparam logic [2:0] PIT_MODE_SWSTB = 3'h4;
    localparam logic [2:0] PIT_MODE_HWSTB = 3'h5;
    // reset and count constants
    localparam logic [15:0] PIT_CNT_ZERO  = 16'h0000;
    localparam logic [15:0] PIT_CNT_ONE   = 16'h0001;
    localparam logic [15:0] PIT_CNT_TWO   = 16'h0002;
    localparam logic [1:0]  PIT_ACC_RST   = 2'h3;
    localparam logic [2:0]  PIT_MODE_RST  = 3'h0;
    localparam logic [7:0]  PIT_RD_UNMAP  = 8'h00;
endpackage

// file: hdl/pit_top.sv
/*
 * three 16-bit down-counters with gate inputs and waveform outputs,
 * programmed through control word and count bytes over classic wishbone.
 * assumes count clocks and gates are synchronous to clk_i and that each
 * count clock high and low phase lasts at least one clk_i period.
 */
`timescale 1ns/1ps
module pit_top #(
    parameter int NUM_CNT = 3,
    parameter int ADR_W   = 4
) (
    // system
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [ADR_W-1:0]   adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    // counter pins
    input  wire logic [NUM_CNT-1:0] count_clk_i,
    input  wire logic [NUM_CNT-1:0] counter_gate_inputs_i,
    output logic      [NUM_CNT-1:0] counter_outputs_o
);

    // one digit-wise or binary decrement by one
    function automatic logic [15:0] pit_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        brw;
        r   = v;
        brw = 1'b1;
        if (!bcd) begin
            r = v - pit_pkg::PIT_CNT_ONE;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (brw) begin
                    if (r[4*k +: 4] == 4'h0) begin
                        r[4*k +: 4] = 4'h9;
                    end else begin
                        r[4*k +: 4] = r[4*k +: 4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // bus request decode, acting once per cycle
    logic       req;
    logic       wr_req;
    logic       rd_req;
    logic [1:0] idx;
    logic [7:0] wbyte;
    logic       ack_q;
    assign req    = cyc_i & stb_i & ~ack_q;
    // writes land at the edge where the master samples ack high
    assign wr_req = cyc_i & stb_i & ack_q & we_i & sel_i[0];
    assign rd_req = req & ~we_i;
    assign idx    = adr_i[pit_pkg::PIT_IDX_LSB +: 2];
    assign wbyte  = dat_i[7:0];

    // control word fields
    logic [1:0] cw_sel;
    logic [1:0] cw_acc;
    logic [2:0] cw_mode;
    logic       cw_bcd;
    logic       cw_wr;
    assign cw_sel  = wbyte[pit_pkg::PIT_CW_SEL_LSB +: 2];
    assign cw_acc  = wbyte[pit_pkg::PIT_CW_ACC_LSB +: 2];
    assign cw_mode = wbyte[pit_pkg::PIT_CW_MODE_LSB +: 3];
    assign cw_bcd  = wbyte[pit_pkg::PIT_CW_BCD_BIT];
    assign cw_wr   = wr_req && idx == pit_pkg::PIT_IDX_CTRL
                     && cw_sel != pit_pkg::PIT_SEL_ILLEGAL;

    logic [7:0] rd_byte [NUM_CNT];

    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_cnt
            logic [2:0]  mode_q;
            logic        bcd_q;
            logic [1:0]  acc_q;
            logic [15:0] reload_q;
            logic [15:0] count_q;
            logic [15:0] latch_q;
            logic        latched_q;
            logic        rd_msb_q;
            logic        wr_msb_q;
            logic        load_pend_q;
            logic        hold_q;
            logic        armed_q;
            logic        extra_q;
            logic        out_q;
            logic        cclk_prev_q;
            logic        gate_prev_q;
            logic        trig_q;
            logic        sel_cw;
            logic        cmd_prog;
            logic        cmd_latch;
            logic        wr_cnt;
            logic        rd_cnt;
            logic        full_wr;
            logic        part_wr;
            logic        cedge;
            logic        gate;
            logic        is_rate;
            logic        is_sqr;
            logic [15:0] dec1;
            logic [15:0] sq_load;
            logic [15:0] rd_val;

            assign sel_cw    = cw_wr && cw_sel == 2'(g);
            assign cmd_latch = sel_cw && cw_acc == pit_pkg::PIT_ACC_LATCH;
            assign cmd_prog  = sel_cw && cw_acc != pit_pkg::PIT_ACC_LATCH;
            assign wr_cnt    = wr_req && idx == 2'(g);
            assign rd_cnt    = rd_req && idx == 2'(g);
            assign full_wr   = wr_cnt && (acc_q != pit_pkg::PIT_ACC_BOTH || wr_msb_q);
            assign part_wr   = wr_cnt && acc_q == pit_pkg::PIT_ACC_BOTH && !wr_msb_q;
            assign cedge     = count_clk_i[g] & ~cclk_prev_q;
            assign gate      = counter_gate_inputs_i[g];
            // top bit ignored for rate and square
            assign is_rate   = mode_q[1:0] == pit_pkg::PIT_MODE_RATE;
            assign is_sqr    = mode_q[1:0] == pit_pkg::PIT_MODE_SQR;
            assign dec1      = pit_dec(count_q, bcd_q);
            // even half-period start; odd counts get one extra high clock
            assign sq_load   = {reload_q[15:1], 1'b0};

            // control word and byte pointers
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mode_q   <= pit_pkg::PIT_MODE_RST;
                    bcd_q    <= 1'b0;
                    acc_q    <= pit_pkg::PIT_ACC_RST;
                    wr_msb_q <= 1'b0;
                end else if (cmd_prog) begin
                    mode_q   <= cw_mode;
                    bcd_q    <= cw_bcd;
                    acc_q    <= cw_acc;
                    wr_msb_q <= 1'b0;
                end else if (wr_cnt && acc_q == pit_pkg::PIT_ACC_BOTH) begin
                    wr_msb_q <= ~wr_msb_q;
                end
            end

            // count register written by software
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    reload_q <= pit_pkg::PIT_CNT_ZERO;
                end else if (wr_cnt) begin
                    case (acc_q)
                        pit_pkg::PIT_ACC_LSB: reload_q <= {8'h00, wbyte};
                        pit_pkg::PIT_ACC_MSB: reload_q <= {wbyte, 8'h00};
                        default: begin
                            if (wr_msb_q) begin
                                reload_q[15:8] <= wbyte;
                            end else begin
                                reload_q[7:0] <= wbyte;
                            end
                        end
                    endcase
                end
            end

            // gate edge detect; trigger held until a count edge uses it
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    // track pin levels so a high pin gives no false edge at release
                    gate_prev_q <= gate;
                    cclk_prev_q <= count_clk_i[g];
                    trig_q      <= 1'b0;
                end else begin
                    gate_prev_q <= gate;
                    cclk_prev_q <= count_clk_i[g];
                    if (gate && !gate_prev_q) begin
                        trig_q <= 1'b1;
                    end else if (cedge || cmd_prog) begin
                        trig_q <= 1'b0;
                    end
                end
            end

            // counting engine and output waveform
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    count_q     <= pit_pkg::PIT_CNT_ZERO;
                    load_pend_q <= 1'b0;
                    hold_q      <= 1'b0;
                    armed_q     <= 1'b0;
                    extra_q     <= 1'b0;
                    out_q       <= 1'b0;
                end else if (cmd_prog) begin
                    count_q     <= pit_pkg::PIT_CNT_ZERO;
                    load_pend_q <= 1'b0;
                    hold_q      <= 1'b0;
                    armed_q     <= 1'b0;
                    extra_q     <= 1'b0;
                    out_q       <= cw_mode != pit_pkg::PIT_MODE_TC;
                end else begin
                    // stop at first byte, resume on full count
                    if (part_wr && mode_q == pit_pkg::PIT_MODE_TC) begin
                        hold_q <= 1'b1;
                    end
                    if (full_wr && mode_q != pit_pkg::PIT_MODE_ONESH
                        && mode_q != pit_pkg::PIT_MODE_HWSTB) begin
                        if (!armed_q || mode_q == pit_pkg::PIT_MODE_TC
                            || mode_q == pit_pkg::PIT_MODE_SWSTB) begin
                            load_pend_q <= 1'b1;
                        end
                        hold_q <= 1'b0;
                        if (mode_q == pit_pkg::PIT_MODE_TC) begin
                            out_q <= 1'b0;
                        end
                    end
                    // low gate forces output high at once
                    if ((is_rate || is_sqr) && !gate) begin
                        out_q   <= 1'b1;
                        armed_q <= 1'b0;
                    end else if (cedge) begin
                        case (mode_q)
                            pit_pkg::PIT_MODE_TC, pit_pkg::PIT_MODE_SWSTB: begin
                                if (load_pend_q && !full_wr) begin
                                    count_q     <= reload_q;
                                    load_pend_q <= 1'b0;
                                    armed_q     <= 1'b1;
                                end else if (armed_q && !hold_q && !gate
                                             && mode_q == pit_pkg::PIT_MODE_SWSTB) begin
                                    // low gate restarts from loaded value
                                    load_pend_q <= 1'b1;
                                end else if (armed_q && !hold_q && gate) begin
                                    count_q <= dec1;
                                    if (dec1 == pit_pkg::PIT_CNT_ZERO) begin
                                        out_q <= mode_q == pit_pkg::PIT_MODE_TC;
                                        armed_q <= mode_q == pit_pkg::PIT_MODE_TC;
                                    end else begin
                                        out_q <= out_q | (mode_q == pit_pkg::PIT_MODE_SWSTB);
                                    end
                                end else begin
                                    out_q <= out_q | (mode_q == pit_pkg::PIT_MODE_SWSTB);
                                end
                            end
                            pit_pkg::PIT_MODE_ONESH, pit_pkg::PIT_MODE_HWSTB: begin
                                if (trig_q) begin
                                    count_q <= reload_q;
                                    armed_q <= 1'b1;
                                    out_q   <= mode_q == pit_pkg::PIT_MODE_HWSTB;
                                end else if (armed_q) begin
                                    count_q <= dec1;
                                    if (dec1 == pit_pkg::PIT_CNT_ZERO) begin
                                        out_q   <= mode_q == pit_pkg::PIT_MODE_ONESH;
                                        armed_q <= 1'b0;
                                    end else begin
                                        out_q <= out_q | (mode_q == pit_pkg::PIT_MODE_HWSTB);
                                    end
                                end else begin
                                    out_q <= 1'b1;
                                end
                            end
                            default: begin
                                if (trig_q || (load_pend_q && !full_wr)) begin
                                    // start after load or gate edge
                                    count_q     <= is_sqr ? sq_load : reload_q;
                                    extra_q     <= is_sqr & reload_q[0];
                                    load_pend_q <= 1'b0;
                                    armed_q     <= 1'b1;
                                    out_q       <= 1'b1;
                                end else if (armed_q && is_rate) begin
                                    // low for one clock every n
                                    if (count_q == pit_pkg::PIT_CNT_ONE) begin
                                        count_q <= reload_q;
                                        out_q   <= 1'b1;
                                    end else begin
                                        count_q <= dec1;
                                        out_q   <= dec1 != pit_pkg::PIT_CNT_ONE;
                                    end
                                end else if (armed_q) begin
                                    if (count_q == pit_pkg::PIT_CNT_TWO && extra_q) begin
                                        extra_q <= 1'b0;
                                    end else if (count_q == pit_pkg::PIT_CNT_TWO) begin
                                        count_q <= sq_load;
                                        out_q   <= ~out_q;
                                        extra_q <= ~out_q & reload_q[0];
                                    end else begin
                                        count_q <= pit_dec(dec1, bcd_q);
                                    end
                                end
                            end
                        endcase
                    end
                end
            end

            // snapshot and read pointer; a held latch ignores new latch commands
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    latch_q   <= pit_pkg::PIT_CNT_ZERO;
                    latched_q <= 1'b0;
                    rd_msb_q  <= 1'b0;
                end else if (cmd_prog) begin
                    latched_q <= 1'b0;
                    rd_msb_q  <= 1'b0;
                end else begin
                    if (cmd_latch && !latched_q) begin
                        latch_q   <= rd_val;
                        latched_q <= 1'b1;
                    end else if (rd_cnt && latched_q
                                 && (acc_q != pit_pkg::PIT_ACC_BOTH || rd_msb_q)) begin
                        latched_q <= 1'b0;
                    end
                    if (rd_cnt && acc_q == pit_pkg::PIT_ACC_BOTH) begin
                        rd_msb_q <= ~rd_msb_q;
                    end
                end
            end

            // unloaded counter reads the count register, not the cleared zero
            // direct reads are only stable while halted
            assign rd_val = (armed_q || load_pend_q) ? count_q : reload_q;

            // byte presented for a read
            always_comb begin
                logic [15:0] v;
                v = latched_q ? latch_q : rd_val;
                case (acc_q)
                    pit_pkg::PIT_ACC_MSB: rd_byte[g] = v[15:8];
                    pit_pkg::PIT_ACC_BOTH: rd_byte[g] = rd_msb_q ? v[15:8] : v[7:0];
                    default: rd_byte[g] = v[7:0];
                endcase
            end

            assign counter_outputs_o[g] = out_q;
        end
    endgenerate

    // bus answer: one wait state, registered data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (rd_req) begin
                if (idx == pit_pkg::PIT_IDX_CTRL || int'(idx) >= NUM_CNT) begin
                    dat_o <= {24'h000000, pit_pkg::PIT_RD_UNMAP};
                end else begin
                    dat_o <= {24'h000000, rd_byte[idx]};
                end
            end
        end
    end

    assign ack_o = ack_q;

endmodule

// file: test/pit_top_properties.sv
/* port checker for the interval timer, bound into pit_top.
   assumes count clocks and gates are synchronous to clk_i. */
`timescale 1ns/1ps
module pit_checker #(
    parameter int NUM_CNT = 3,
    parameter int ADR_W   = 4
) (
    // bus side
    input wire logic               clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [ADR_W-1:0]   adr_i,
    input wire logic [31:0]        dat_o,
    // counter pins
    input wire logic [NUM_CNT-1:0] count_clk_i, counter_gate_inputs_i,
    input wire logic [NUM_CNT-1:0] counter_outputs_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request is taken only while ack is low
    wire logic take = cyc_i && stb_i && !ack_o;
    chk_ack_next: assert property (take |=> ack_o)
        else $error("request not acked");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    chk_ack_cause: assert property (ack_o |-> $past(take))
        else $error("ack without request");
    chk_rd_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_ctrl_rd_zero: assert property (take && !we_i && adr_i[3:2] == 2'h3 |=>
        dat_o == 32'h00000000) else $error("control word readable");
    chk_dat_hold: assert property (!$past(take && !we_i) |-> $stable(dat_o))
        else $error("read data moved without read");
    // outputs 0 and 1 only move after a count event, a gate change or a write
    chk_out0_cause: assert property ($changed(counter_outputs_o[0]) |->
        $past(count_clk_i[0]) && !$past(count_clk_i[0], 2) ||
        $past(counter_gate_inputs_i[0]) != $past(counter_gate_inputs_i[0], 2) ||
        $past(take && we_i) || $past(take && we_i, 2)) else $error("output 0 moved");
    chk_out1_cause: assert property ($changed(counter_outputs_o[1]) |->
        $past(count_clk_i[1]) && !$past(count_clk_i[1], 2) ||
        $past(counter_gate_inputs_i[1]) != $past(counter_gate_inputs_i[1], 2) ||
        $past(take && we_i) || $past(take && we_i, 2)) else $error("output 1 moved");
endmodule

bind pit_top pit_checker #(.NUM_CNT(NUM_CNT), .ADR_W(ADR_W)) u_pit_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .ack_o(ack_o), .adr_i(adr_i), .dat_o(dat_o), .count_clk_i(count_clk_i),
    .counter_gate_inputs_i(counter_gate_inputs_i), .counter_outputs_o(counter_outputs_o));

// file: test/pit_host.sv
/* bus master standing in for the processor: classic wishbone single cycles.
   assumes a slave that acks every request. */
`timescale 1ns/1ps
module pit_host (
    // system and answer
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    // request
    output logic             cyc_o = 1'b0,
    output logic             stb_o = 1'b0,
    output logic             we_o  = 1'b0,
    output logic [3:0]       adr_o = 4'h0,
    output logic [31:0]      dat_o = 32'h00000000
);
    task automatic xfer(input logic w, input logic [1:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'h0};
        dat_o <= {24'h000000, wd};
        // hold the request until ack is seen at an edge
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
endmodule

// file: test/pit_top_tb_top.sv
/* self-checking bench for pit_top: host tasks plus count clock and gates.
   assumes the checker is bound in and all counters share one count clock. */
`timescale 1ns/1ps
module pit_top_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [2:0]  cclk  = 3'h0;
    logic [2:0]  gate  = 3'h7;
    logic [2:0]  out;
    logic        cyc, stb, we, ack;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  b, lo, hi;
    int          mismatches = 0;
    int          n_compared = 0;
    int          k;
    always #5 clk_i = ~clk_i;
    // each count clock phase lasts one clk_i, the fastest allowed
    always @(posedge clk_i) cclk <= ~cclk;
    pit_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .count_clk_i(cclk), .counter_gate_inputs_i(gate), .counter_outputs_o(out));
    pit_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .dat_o(wdat));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // low cycles over a window that spans whole periods
    task automatic lows(input int ch, input int len, input int exp);
        int c;
        c = 0;
        repeat (len) begin
            @(negedge clk_i);
            c += (out[ch] === 1'b0);
        end
        check(c[7:0], exp[7:0]);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog, tests need well under 5000 cycles
    initial begin
        #50000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        host.xfer(1'b1, 2'h3, 8'h14, b);
        @(negedge clk_i); check({7'h0, out[0]}, 8'h01);
        host.xfer(1'b1, 2'h0, 8'h03, b);
        host.xfer(1'b1, 2'h3, 8'hD0, b);
        repeat (10) @(posedge clk_i);
        lows(0, 60, 20);
        host.xfer(1'b1, 2'h0, 8'h04, b);
        repeat (12) @(posedge clk_i);
        lows(0, 64, 16);
        @(posedge clk_i) gate[0] <= 1'b0;
        repeat (2) @(negedge clk_i);
        lows(0, 10, 0);
        @(posedge clk_i) gate[0] <= 1'b1;
        host.xfer(1'b1, 2'h3, 8'h56, b);
        host.xfer(1'b1, 2'h1, 8'h05, b);
        repeat (12) @(posedge clk_i);
        lows(1, 100, 40);
        host.xfer(1'b1, 2'h3, 8'h5E, b);
        host.xfer(1'b1, 2'h1, 8'h06, b);
        repeat (12) @(posedge clk_i);
        lows(1, 96, 48);
        @(posedge clk_i) gate[2] <= 1'b0;
        host.xfer(1'b1, 2'h3, 8'hB1, b);
        host.xfer(1'b1, 2'h2, 8'h34, b);
        host.xfer(1'b1, 2'h2, 8'h12, b);
        repeat (8) @(posedge clk_i);
        host.xfer(1'b1, 2'h3, 8'h80, b);
        gate[2] <= 1'b1;
        repeat (20) @(posedge clk_i);
        host.xfer(1'b1, 2'h3, 8'h80, b);
        host.xfer(1'b0, 2'h2, 8'h00, lo); check(lo, 8'h34);
        host.xfer(1'b0, 2'h2, 8'h00, hi); check(hi, 8'h12);
        host.xfer(1'b1, 2'h3, 8'h80, b);
        host.xfer(1'b0, 2'h2, 8'h00, lo);
        host.xfer(1'b0, 2'h2, 8'h00, hi);
        check({7'h0, lo[3:0] < 4'hA && lo[7:4] < 4'hA && hi[3:0] < 4'hA && {hi, lo} < 16'h1234},
            8'h01);
        host.xfer(1'b1, 2'h3, 8'h90, b);
        @(negedge clk_i); check({7'h0, out[2]}, 8'h00);
        host.xfer(1'b1, 2'h2, 8'h04, b);
        k = 0;
        while (out[2] !== 1'b1 && k < 200) begin
            @(negedge clk_i);
            k++;
        end
        check({7'h0, k > 6 && k < 14}, 8'h01);
        lows(2, 40, 0);
        host.xfer(1'b1, 2'h3, 8'h18, b);
        host.xfer(1'b1, 2'h0, 8'h03, b);
        lows(0, 60, 2);
        host.xfer(1'b1, 2'h3, 8'h1A, b);
        host.xfer(1'b1, 2'h0, 8'h03, b);
        lows(0, 30, 0);
        @(posedge clk_i) gate[0] <= 1'b0;
        @(posedge clk_i) gate[0] <= 1'b1;
        lows(0, 40, 2);
        host.xfer(1'b1, 2'h3, 8'h52, b);
        host.xfer(1'b1, 2'h1, 8'h03, b);
        lows(1, 30, 0);
        @(posedge clk_i) gate[1] <= 1'b0;
        @(posedge clk_i) gate[1] <= 1'b1;
        lows(1, 40, 6);
        host.xfer(1'b1, 2'h3, 8'h62, b);
        host.xfer(1'b1, 2'h1, 8'h01, b);
        host.xfer(1'b0, 2'h1, 8'h00, b); check(b, 8'h01);
        host.xfer(1'b0, 2'h3, 8'h00, b); check(b, 8'h00);
        report_and_stop();
    end
endmodule
